// ### core/pid_map.svh
// Register offsets, field positions, reset values and timing counts of the pressure loop
// Overview of operation
// R1: Actuator select: flow controller, ratio, valve, none
// R2: Output is gain times error, integral, derivative
// R3: Error sign follows upstream or downstream direction
// R4: Proportional gain 0.002 to 10000, default 10
// R5: Integral constant 0.01 to 10000 s, default 1
// R6: Derivative constant 0 to 1000 s, default 0.2
// R7: Software zeroes derivative for flow controllers; the code applies the derivative term for every actuator
// R8: Output never exceeds Ceiling percentage
// R9: Ceiling from Base plus 10 to 100
// R10: Termination loads Preset in set-point mode
// R11: Preset 0 to 100, default closed
// R12: Output never falls below Base percentage
// R13: Base 0 to 100, default 0, at most Start
// R14: Base above Start replaces ramp start
// R15: Ramp start clamped between Base and Ceiling
// R16: Ramp end clamped between Base and Ceiling
// R17: Ramp start to end over ramp duration
// R18: Zero ramp duration goes straight to control
// R19: Flow controllers upstream, valve forced downstream
// R20: Scheduling band 0 to 30, default 0
// R21: Inside band divide gain by divisor 1..200
// R22: Idle recipe fully writable
// R23: Running recipe accepts only target and gains
// R24: Gain changes keep integral; restart clears it
// R25: Fixed sample period, saturating fixed-point arithmetic
// R26: Bad or misordered writes rejected, value kept
`ifndef PID_MAP_SVH
`define PID_MAP_SVH

// Register byte offsets
`define OFS_CONTROL     8'h00
`define OFS_STATUS      8'h04
`define OFS_CONFIG      8'h08
`define OFS_TARGET      8'h0c
`define OFS_PGAIN       8'h10
`define OFS_ICONST      8'h14
`define OFS_DCONST      8'h18
`define OFS_CEILING     8'h1c
`define OFS_BASE        8'h20
`define OFS_PRESET      8'h24
`define OFS_START       8'h28
`define OFS_END         8'h2c
`define OFS_RAMP        8'h30
`define OFS_BAND        8'h34
`define OFS_DIVISOR     8'h38
`define OFS_DRIVE       8'h3c

// Config field positions
`define CFG_ACT_LSB     0
`define CFG_ACT_MSB     1
`define CFG_DIR_BIT     2
`define CFG_SENS_LSB    3
`define CFG_SENS_MSB    4
`define CFG_CHAN_LSB    5
`define CFG_CHAN_MSB    7

// Percent quantities are in 0.01 % steps
`define PCT_FULL        16'd10000
`define PCT_GAP         16'd1000
`define BAND_MAX        16'd3000
`define DIV_MIN         8'd1
`define DIV_MAX         8'd200
// Gain in 0.001 steps, time constants in ms
`define PGAIN_MIN       32'd2
`define PGAIN_MAX       32'd10000000
`define ICONST_MIN      32'd10
`define ICONST_MAX      32'd10000000
`define DCONST_MAX      32'd1000000

// Reset values
`define RST_PGAIN       32'd10000
`define RST_ICONST      32'd1000
`define RST_DCONST      32'd200
`define RST_CEILING     16'd10000
`define RST_DIVISOR     8'd1
`define RST_CONFIG      8'h03

// Timing
`define CLK_MHZ         100
`define SAMPLE_US       1000
`define SAMPLE_CYCLES   (`SAMPLE_US * `CLK_MHZ)
`define SAMPLES_PER_S   (1000000 / `SAMPLE_US)
`define INTEG_LIMIT     64'sh0000_0100_0000_0000
`define ERR_LIMIT       64'sd1000000

`endif

// ### core/pid_pkg.sv
// Types shared by the pressure loop
package pid_pkg;
   typedef enum logic [1:0] {ACT_SINGLE, ACT_RATIO, ACT_VALVE, ACT_NONE} actuator_t;
   typedef enum logic [1:0] {ST_IDLE, ST_RAMP, ST_CONTROL} loop_state_t;
   typedef enum logic [1:0] {DRV_SETPOINT, DRV_RAMP, DRV_PID} drive_mode_t;
   typedef struct packed
   {
      drive_mode_t mode;     // What is steering the actuator
      actuator_t   actuator; // Which actuator kind is driven
      logic [2:0]  channel;  // Flow controller channel
      logic [15:0] level;    // Drive level, 0.01 % steps
   } drive_t;
endpackage

// ### core/pid_pressure_loop.sv
// PID pressure loop with APB register slave
`timescale 1ns/1ps
`include "pid_map.svh"

module pid_pressure_loop
#(
   parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES  // Clock cycles per sample period
)
(
   input  wire logic              mclk,        // 100 MHz clock
   input  wire logic              sys_rst,     // Synchronous reset, active high
   input  wire logic              psel,        // APB select
   input  wire logic              penable,     // APB enable
   input  wire logic              pwrite,      // APB direction
   input  wire logic [7:0]        paddr,       // APB byte address
   input  wire logic [31:0]       pwdata,      // APB write data
   output logic      [31:0]       prdata,      // APB read data
   output logic                   pready,      // APB ready
   output logic                   pslverr,     // APB error
   input  wire logic [3:0][31:0]  pressure_in, // Pressure sensor readings
   output pid_pkg::drive_t        drive        // Actuator drive
);

   // Synchronised sensor readings
   logic [3:0][31:0]     sens_meta;      // First stage
   logic [3:0][31:0]     sens_sync;      // Second stage
   // Recipe registers
   logic [7:0]           config_r;       // Actuator, direction, sensor, channel
   logic [31:0]          pressure_target;
   logic [31:0]          proportional_gain;
   logic [31:0]          integral_constant;
   logic [31:0]          derivative_constant;
   logic [15:0]          ceiling;
   logic [15:0]          base;
   logic [15:0]          preset;
   logic [15:0]          start_lvl;
   logic [15:0]          end_lvl;
   logic [15:0]          ramp_duration;   // Seconds
   logic [15:0]          reduced_gain_band;
   logic [7:0]           gain_reduction_divisor;
   // Loop state
   pid_pkg::loop_state_t state;
   logic [31:0]          tick_cnt;        // Sample period counter
   logic                 tick;            // One cycle per sample
   logic [31:0]          ramp_cnt;        // Samples spent ramping
   logic signed [63:0]   integ;           // Accumulated error
   logic signed [63:0]   prev_err;        // Error of last sample
   logic                 last_rejected;   // Last write refused
   // Decoded bus strobes
   logic                 wr_en;
   logic                 rd_setup;
   logic                 mapped;
   logic                 accept;
   logic                 start_req;
   logic                 stop_req;

   pid_pkg::actuator_t   actuator;
   logic                 downstream;
   logic [31:0]          pressure_meas;

   assign actuator = pid_pkg::actuator_t'(config_r[`CFG_ACT_MSB:`CFG_ACT_LSB]);
   // Flow controllers run upstream; a valve always runs downstream
   assign downstream = (actuator == pid_pkg::ACT_VALVE); // R19
   assign pressure_meas = sens_sync[config_r[`CFG_SENS_MSB:`CFG_SENS_LSB]];

   // Clamp a signed value into [lo, hi]
   function automatic logic [15:0] clamp_pct(input logic signed [63:0] v,
                                             input logic [15:0] lo,
                                             input logic [15:0] hi);
      logic [15:0] r;
      r = v[15:0];
      if (v < $signed({48'd0, lo}))
      begin
         r = lo;
      end
      else if (v > $signed({48'd0, hi}))
      begin
         r = hi;
      end
      return r;
   endfunction

   // Saturate to a symmetric limit
   function automatic logic signed [63:0] sat(input logic signed [63:0] v,
                                              input logic signed [63:0] lim);
      logic signed [63:0] r;
      r = v;
      if (v > lim)
      begin
         r = lim;
      end
      else if (v < -lim)
      begin
         r = -lim;
      end
      return r;
   endfunction

   // Two flip-flop synchroniser for the sensor inputs
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         sens_meta <= '0;
         sens_sync <= '0;
      end
      else
      begin
         sens_meta <= pressure_in;
         sens_sync <= sens_meta;
      end
   end

   // APB decode: zero wait states
   assign pready   = 1'b1;
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable;

   always_comb
   begin
      mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFS_DRIVE);
   end

   // Range and ordering checks, and the running-recipe lock
   always_comb
   begin
      accept = 1'b0;
      if (mapped)
      begin
         case (paddr)
            `OFS_CONTROL: accept = 1'b1;
            `OFS_TARGET:  accept = 1'b1; // R23
            `OFS_PGAIN:   accept = pwdata >= `PGAIN_MIN && pwdata <= `PGAIN_MAX; // R4
            `OFS_ICONST:  accept = pwdata >= `ICONST_MIN && pwdata <= `ICONST_MAX; // R5
            `OFS_DCONST:  accept = pwdata <= `DCONST_MAX; // R6
            `OFS_CONFIG:  accept = (state == pid_pkg::ST_IDLE) && pwdata[31:8] == '0; // R1
            `OFS_CEILING: accept = (state == pid_pkg::ST_IDLE) && pwdata[31:16] == '0
                                   && pwdata[15:0] <= `PCT_FULL
                                   && {16'd0, pwdata[15:0]} >= {16'd0, base} + 32'(`PCT_GAP); // R9
            `OFS_BASE:    accept = (state == pid_pkg::ST_IDLE) && pwdata[31:16] == '0
                                   && pwdata[15:0] <= start_lvl && pwdata[15:0] <= end_lvl
                                   && {16'd0, pwdata[15:0]} + 32'(`PCT_GAP)
                                      <= {16'd0, ceiling}; // R13
            `OFS_PRESET:  accept = (state == pid_pkg::ST_IDLE) && pwdata <= 32'(`PCT_FULL); // R11
            `OFS_START:   accept = (state == pid_pkg::ST_IDLE) && pwdata <= 32'(`PCT_FULL)
                                   && pwdata[15:0] >= base; // R15
            `OFS_END:     accept = (state == pid_pkg::ST_IDLE) && pwdata <= 32'(`PCT_FULL)
                                   && pwdata[15:0] >= base; // R16
            `OFS_RAMP:    accept = (state == pid_pkg::ST_IDLE) && pwdata[31:16] == '0;
            `OFS_BAND:    accept = (state == pid_pkg::ST_IDLE) && pwdata <= 32'(`BAND_MAX); // R20
            `OFS_DIVISOR: accept = (state == pid_pkg::ST_IDLE) && pwdata >= 32'(`DIV_MIN)
                                   && pwdata <= 32'(`DIV_MAX); // R21
            default:      accept = 1'b0;
         endcase
      end
   end

   assign start_req = wr_en && accept && paddr == `OFS_CONTROL && pwdata[0]
                      && actuator != pid_pkg::ACT_NONE && state == pid_pkg::ST_IDLE; // R1
   assign stop_req  = wr_en && accept && paddr == `OFS_CONTROL && !pwdata[0];

   // Recipe register writes; refused writes keep the old value
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         config_r               <= `RST_CONFIG;
         pressure_target        <= '0;
         proportional_gain      <= `RST_PGAIN;
         integral_constant      <= `RST_ICONST;
         derivative_constant    <= `RST_DCONST;
         ceiling                <= `RST_CEILING;
         base                   <= '0;
         preset                 <= '0;
         start_lvl              <= '0;
         end_lvl                <= '0;
         ramp_duration          <= '0;
         reduced_gain_band      <= '0;
         gain_reduction_divisor <= `RST_DIVISOR;
      end
      else if (wr_en && accept) // R22 R26
      begin
         case (paddr)
            `OFS_CONFIG:  config_r               <= pwdata[7:0];
            `OFS_TARGET:  pressure_target        <= pwdata;
            `OFS_PGAIN:   proportional_gain      <= pwdata;
            `OFS_ICONST:  integral_constant      <= pwdata;
            `OFS_DCONST:  derivative_constant    <= pwdata;
            `OFS_CEILING: ceiling                <= pwdata[15:0];
            `OFS_BASE:    base                   <= pwdata[15:0];
            `OFS_PRESET:  preset                 <= pwdata[15:0];
            `OFS_START:   start_lvl              <= pwdata[15:0];
            `OFS_END:     end_lvl                <= pwdata[15:0];
            `OFS_RAMP:    ramp_duration          <= pwdata[15:0];
            `OFS_BAND:    reduced_gain_band      <= pwdata[15:0];
            `OFS_DIVISOR: gain_reduction_divisor <= pwdata[7:0];
            default:      config_r               <= config_r;
         endcase
      end
   end

   // Error flag and read data, registered in the setup cycle
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         prdata        <= '0;
         pslverr       <= 1'b0;
         last_rejected <= 1'b0;
      end
      else
      begin
         if (wr_en)
         begin
            last_rejected <= !accept; // R26
         end
         if (rd_setup)
         begin
            pslverr <= !mapped || (pwrite && !accept);
            case (paddr)
               `OFS_CONTROL: prdata <= {31'd0, state != pid_pkg::ST_IDLE};
               `OFS_STATUS:  prdata <= {29'd0, last_rejected, state};
               `OFS_CONFIG:  prdata <= {24'd0, config_r[7:3], downstream, config_r[1:0]};
               `OFS_TARGET:  prdata <= pressure_target;
               `OFS_PGAIN:   prdata <= proportional_gain;
               `OFS_ICONST:  prdata <= integral_constant;
               `OFS_DCONST:  prdata <= derivative_constant;
               `OFS_CEILING: prdata <= {16'd0, ceiling};
               `OFS_BASE:    prdata <= {16'd0, base};
               `OFS_PRESET:  prdata <= {16'd0, preset};
               `OFS_START:   prdata <= {16'd0, start_lvl};
               `OFS_END:     prdata <= {16'd0, end_lvl};
               `OFS_RAMP:    prdata <= {16'd0, ramp_duration};
               `OFS_BAND:    prdata <= {16'd0, reduced_gain_band};
               `OFS_DIVISOR: prdata <= {24'd0, gain_reduction_divisor};
               `OFS_DRIVE:   prdata <= {16'd0, drive.level};
               default:      prdata <= '0;
            endcase
         end
      end
   end

   // Fixed sample period
   always_ff @(posedge mclk)
   begin
      if (sys_rst || tick)
      begin
         tick_cnt <= '0;
      end
      else
      begin
         tick_cnt <= tick_cnt + 32'd1;
      end
   end
   assign tick = (tick_cnt == 32'(SAMPLE_CYCLES - 1)); // R25

   // Ramp endpoints and PID computation
   logic [15:0]        eff_start;
   logic [15:0]        eff_end;
   logic [31:0]        ramp_total;
   logic signed [63:0] ramp_level;
   logic signed [63:0] raw_err;
   logic signed [63:0] err;
   logic signed [63:0] next_integ;
   logic signed [63:0] pid_sum;
   logic signed [63:0] kp_eff;
   logic signed [63:0] pid_out;
   logic [63:0]        abs_err;

   always_comb
   begin
      eff_start  = clamp_pct({48'd0, start_lvl}, base, ceiling); // R14 R15
      eff_end    = clamp_pct({48'd0, end_lvl}, base, ceiling); // R16
      ramp_total = 32'(ramp_duration) * 32'(`SAMPLES_PER_S);
      ramp_level = $signed({48'd0, eff_start});
      if (ramp_total != '0)
      begin
         ramp_level = $signed({48'd0, eff_start})
                      + (($signed({48'd0, eff_end}) - $signed({48'd0, eff_start}))
                      * $signed({32'd0, ramp_cnt})) / $signed({32'd0, ramp_total}); // R17
      end
      // Error normalised to 0.01 % of the target, so the gain is unit free
      if (downstream)
      begin
         raw_err = $signed({32'd0, pressure_meas}) - $signed({32'd0, pressure_target}); // R3
      end
      else
      begin
         raw_err = $signed({32'd0, pressure_target}) - $signed({32'd0, pressure_meas}); // R3
      end
      if (pressure_target == '0)
      begin
         err = sat(raw_err * 64'sd10000, `ERR_LIMIT);
      end
      else
      begin
         err = sat((raw_err * 64'sd10000) / $signed({32'd0, pressure_target}),
                   `ERR_LIMIT); // R4 R25
      end
      abs_err    = (err < 0) ? 64'(-err) : 64'(err);
      next_integ = sat(integ + err, `INTEG_LIMIT); // R25
      // Reduced gain close to the target
      kp_eff = $signed({32'd0, proportional_gain});
      if (reduced_gain_band != '0 && abs_err <= {48'd0, reduced_gain_band})
      begin
         kp_eff = kp_eff / $signed({56'd0, gain_reduction_divisor}); // R21
      end
      pid_sum = err + next_integ / $signed({32'd0, integral_constant})
                + $signed({32'd0, derivative_constant}) * (err - prev_err); // R2
      pid_out = sat(sat(pid_sum, 64'sh0000_0000_7fff_ffff) * kp_eff / 64'sd1000,
                    64'sh0000_0000_7fff_ffff); // R25
   end

   // Loop sequencing: idle, ramp, closed-loop control
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state    <= pid_pkg::ST_IDLE;
         ramp_cnt <= '0;
         integ    <= '0;
         prev_err <= '0;
      end
      else
      begin
         case (state)
            pid_pkg::ST_IDLE:
            begin
               if (start_req)
               begin
                  integ    <= '0; // R24
                  prev_err <= '0;
                  ramp_cnt <= '0;
                  state    <= (ramp_duration == '0) ? pid_pkg::ST_CONTROL
                                                    : pid_pkg::ST_RAMP; // R18
               end
            end
            pid_pkg::ST_RAMP:
            begin
               if (stop_req)
               begin
                  state <= pid_pkg::ST_IDLE;
               end
               else if (tick)
               begin
                  if (ramp_cnt >= ramp_total)
                  begin
                     state    <= pid_pkg::ST_CONTROL;
                     prev_err <= err;
                  end
                  else
                  begin
                     ramp_cnt <= ramp_cnt + 32'd1;
                  end
               end
            end
            pid_pkg::ST_CONTROL:
            begin
               if (stop_req)
               begin
                  state <= pid_pkg::ST_IDLE;
               end
               else if (tick)
               begin
                  integ    <= next_integ; // R24
                  prev_err <= err;
               end
            end
            default:
            begin
               state <= pid_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Actuator drive register
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         drive.mode     <= pid_pkg::DRV_SETPOINT;
         drive.actuator <= pid_pkg::ACT_NONE;
         drive.channel  <= '0;
         drive.level    <= '0;
      end
      else
      begin
         drive.actuator <= actuator;
         drive.channel  <= config_r[`CFG_CHAN_MSB:`CFG_CHAN_LSB];
         if (state != pid_pkg::ST_IDLE && stop_req)
         begin
            drive.mode  <= pid_pkg::DRV_SETPOINT; // R10
            drive.level <= preset; // R10
         end
         else if (state == pid_pkg::ST_RAMP)
         begin
            drive.mode  <= pid_pkg::DRV_RAMP;
            drive.level <= clamp_pct(ramp_level, base, ceiling); // R17
         end
         else if (state == pid_pkg::ST_CONTROL && tick)
         begin
            drive.mode  <= pid_pkg::DRV_PID;
            drive.level <= clamp_pct(pid_out, base, ceiling); // R8 R12
         end
      end
   end

endmodule

// ### tb/pressure_plant.sv
// Chamber and sensor model on the far side of the drive
`timescale 1ns/1ps
module pressure_plant
(
   input  wire logic             mclk,        // Clock
   input  wire logic             sys_rst,     // Reset
   input  wire pid_pkg::drive_t  drive,       // Actuator drive
   output logic      [3:0][31:0] pressure_in  // Sensor readings
);
   int p;       // Chamber pressure, raw units
   int inflow;  // Gas gained per cycle
   // Valve opening pumps gas away, flow controllers feed it in
   always_comb inflow = (drive.actuator == pid_pkg::ACT_VALVE) ? 1000 - drive.level / 10
                                                               : drive.level / 8;
   // Chamber leaks a fixed share each cycle
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         p <= 0;
      else
         p <= p + inflow - p / 64;
   end
   // Each sensor reads the chamber with its own small offset
   always_comb for (int i = 0; i < 4; i++) pressure_in[i] = p + i;
endmodule

// ### tb/pid_loop_sva.sv
// Port checker for the pressure loop
`timescale 1ns/1ps
`include "pid_map.svh"
module pid_loop_sva
#(
   parameter int SAMPLE_CYCLES = 16  // Cycles per sample period
)
(
   input wire logic             mclk,        // Clock
   input wire logic             sys_rst,     // Reset
   input wire logic             psel,        // APB select
   input wire logic             penable,     // APB enable
   input wire logic             pwrite,      // APB direction
   input wire logic [7:0]       paddr,       // APB address
   input wire logic [31:0]      pwdata,      // APB write data
   input wire logic [31:0]      prdata,      // APB read data
   input wire logic             pready,      // APB ready
   input wire logic             pslverr,     // APB error
   input wire logic [3:0][31:0] pressure_in, // Sensor readings
   input wire pid_pkg::drive_t  drive        // Actuator drive
);
   logic [15:0] ceil;    // Accepted ceiling
   logic [15:0] base;    // Accepted base
   logic [15:0] preset;  // Accepted preset
   logic [31:0] ramp;    // Accepted ramp time
   logic        acc_w;   // Write taken without error
   logic        active;  // Loop steers the actuator
   logic        setw;    // Write setup cycle
   localparam int PID_WAIT = SAMPLE_CYCLES + 2; // Start to PID drive
   assign acc_w = psel && penable && pwrite && pready && !pslverr;
   assign active = drive.mode != pid_pkg::DRV_SETPOINT;
   assign setw = psel && !penable && pwrite;
   // Shadow the limits from writes that were taken
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         ceil <= `RST_CEILING;
         base <= 16'h0;
         preset <= 16'h0;
         ramp <= 32'h0;
      end
      else if (acc_w)
      begin
         if (paddr == `OFS_CEILING) ceil <= pwdata[15:0];
         if (paddr == `OFS_BASE) base <= pwdata[15:0];
         if (paddr == `OFS_PRESET) preset <= pwdata[15:0];
         if (paddr == `OFS_RAMP) ramp <= pwdata;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence start_w;
      acc_w && paddr == `OFS_CONTROL && pwdata[0] && !active && drive.actuator != pid_pkg::ACT_NONE;
   endsequence
   sequence stop_w;
      acc_w && paddr == `OFS_CONTROL && !pwdata[0] && active;
   endsequence
   ceil_limit_a: assert property (active |-> drive.level <= ceil)
      else $error("drive above ceiling");
   base_floor_a: assert property (active |-> drive.level >= base)
      else $error("drive below base");
   stop_preset_a: assert property (stop_w |-> ##[1:2] !active && drive.level == preset)
      else $error("stop did not load preset");
   skip_ramp_a: assert property (start_w ##0 ramp == 0 |-> ##[1:PID_WAIT]
      drive.mode == pid_pkg::DRV_PID)
      else $error("zero ramp did not go to control");
   ramp_entry_a: assert property (start_w ##0 ramp != 0 |-> ##[1:3]
      drive.mode == pid_pkg::DRV_RAMP)
      else $error("ramp not entered");
   run_lock_a: assert property (setw && paddr == `OFS_CEILING && active |=> pslverr)
      else $error("running ceiling write taken");
   div_range_a: assert property (setw && paddr == `OFS_DIVISOR &&
      (pwdata == 0 || pwdata > 200) |=> pslverr)
      else $error("bad divisor taken");
   ceil_gap_a: assert property (setw && paddr == `OFS_CEILING &&
      pwdata < 32'(base) + 32'd1000 |=> pslverr)
      else $error("ceiling gap not kept");
   act_known_a: assert property (active |-> drive.actuator != pid_pkg::ACT_NONE)
      else $error("loop runs with no actuator");
endmodule
bind pid_pressure_loop pid_loop_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) pid_loop_sva_i (.mclk(mclk),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pressure_in(pressure_in), .drive(drive));

// ### tb/tb.sv
// Self-checking bench for the pressure loop
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
   $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
   localparam int SC = 16;       // Short sample period
   logic             mclk = 0;   // Clock
   logic             sys_rst = 1;// Reset
   logic             psel = 0;   // APB select
   logic             penable = 0;// APB enable
   logic             pwrite = 0; // APB direction
   logic [7:0]       paddr = 0;  // APB address
   logic [31:0]      pwdata = 0; // APB write data
   logic [31:0]      prdata;     // APB read data
   logic [31:0]      rd;         // Last read data
   logic             pready;     // APB ready
   logic             pslverr;    // APB error
   logic             err;        // Last error
   logic [3:0][31:0] pressure_in;// Sensor readings
   pid_pkg::drive_t  drive;      // Actuator drive
   int               errors = 0; // Mismatches
   int               num_checks = 0;
   int               cycles = 0; // Hang guard
   int               seed = 32'h7c6f;
   longint           m [16];     // Register model
   bit               run = 0;    // Model loop running
   always #5 mclk = ~mclk;
   pid_pressure_loop #(.SAMPLE_CYCLES(SC)) pid_pressure_loop_i (.mclk(mclk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pressure_in(pressure_in), .drive(drive));
   pressure_plant pressure_plant_i (.mclk(mclk), .sys_rst(sys_rst), .drive(drive),
      .pressure_in(pressure_in));
   task results;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles > 60000)
      begin
         errors++;
         results();
      end
   end
   // One APB transfer, held until pready is seen
   task apb(input bit w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Whether the model takes a write
   function automatic bit acc(input int i, input longint v);
      if (run && !(i inside {0, 3, 4, 5, 6})) return 0;
      case (i)
         0, 3, 12: return 1;
         1, 15: return 0;
         2: return v < 256;
         4: return v >= 2 && v <= 10000000;
         5: return v >= 10 && v <= 10000000;
         6: return v <= 1000000;
         7: return v <= 10000 && v >= m[8] + 1000;
         8: return v <= 10000 && v <= m[10] && v <= m[11] && v + 1000 <= m[7];
         9: return v <= 10000;
         10, 11: return v <= 10000 && v >= m[8];
         13: return v <= 3000;
         default: return v >= 1 && v <= 200;
      endcase
   endfunction
   // Write, compare the refusal, read back
   task wr(input int i, input longint v);
      bit ok;
      ok = acc(i, v);
      apb(1, 8'(i * 4), v[31:0]);
      `CHK(err, !ok)
      if (ok) m[i] = (i == 2) ? ((v & ~64'd4) | ((v % 4 == 2) ? 4 : 0)) : (i == 0 ? v % 2 : v);
      if (ok && i == 0) run = v[0];
      apb(0, 8'(i * 4), 0);
      `CHK(rd, m[i][31:0])
   endtask
   initial
   begin
      for (int i = 0; i < 16; i++) m[i] = 0;
      m[2] = 3;
      m[4] = 10000;
      m[5] = 1000;
      m[6] = 200;
      m[7] = 10000;
      m[14] = 1;
      repeat (20) @(posedge mclk);
      sys_rst <= 0;
      for (int i = 0; i < 16; i++)
      begin
         apb(0, 8'(i * 4), 0);
         `CHK(rd, m[i][31:0])
      end
      apb(0, 8'h42, 0);
      `CHK({err, rd}, {1'b1, 32'h0})
      for (int a = 0; a < 4; a++) wr(2, a + 32'h58);
      `CHK(drive.channel, 3'd2)
      repeat (150) wr(2 + $unsigned($random(seed)) % 13, $random(seed) & 32'h3fff);
      wr(8, 0);
      wr(7, 9000);
      wr(11, 9500);
      wr(10, 3000);
      wr(8, 2000);
      wr(9, 4000);
      wr(12, 0);
      wr(3, 20000);
      wr(6, 0);
      wr(2, 0);
      wr(0, 1);
      repeat (SC) @(posedge mclk);
      `CHK(drive.mode, pid_pkg::DRV_PID)
      `CHK(drive.actuator, pid_pkg::ACT_SINGLE)
      repeat (40 * SC) @(posedge mclk);
      `CHK(drive.level >= 16'd2000 && drive.level <= 16'd9000, 1'b1)
      wr(7, 8000);
      wr(4, 20000);
      wr(0, 0);
      `CHK({drive.mode, drive.level}, {pid_pkg::DRV_SETPOINT, 16'd4000})
      wr(2, 2);
      wr(12, 1);
      wr(0, 1);
      `CHK(drive.mode, pid_pkg::DRV_RAMP)
      `CHK(drive.level >= 16'd3000 && drive.level <= 16'd3012, 1'b1)
      repeat (999 * SC) @(posedge mclk);
      `CHK(drive.level >= 16'd8970 && drive.level <= 16'd9000, 1'b1)
      repeat (4 * SC) @(posedge mclk);
      `CHK(drive.mode, pid_pkg::DRV_PID)
      wr(0, 0);
      results();
   end
endmodule
